// [inc/otc_pkg.sv]
// Constants shared by the over-temperature threshold comparator.
// Assumes a 100 MHz system clock and an 8-bit register port.
package otc_pkg;

    // Register offsets (16-bit address space)
    localparam logic [15:0] ADDR_LIMIT = 16'hFE76;
    localparam logic [15:0] ADDR_STATUS = 16'hFF00;
    localparam logic [15:0] ADDR_MASK = 16'hFF01;
    localparam logic [15:0] ADDR_STATE = 16'hFF02;

    // Reset values
    localparam logic [7:0] LIMIT_RESET = 8'h00;
    localparam logic [2:0] STATUS_RESET = 3'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;

    // Status and mask bit positions
    localparam int ST_RISE = 0;
    localparam int ST_FALL = 1;
    localparam int ST_BADLIM = 2;
    localparam int ST_W = 3;

    // State register bit positions
    localparam int SR_FLAG = 0;
    localparam int SR_RAW = 1;

    // Legal threshold code range for software
    localparam logic [7:0] LIMIT_MIN = 8'h02;
    localparam logic [7:0] LIMIT_MAX = 8'hF4;

    // Widths
    localparam int LIMIT_W = 8;
    localparam int CMP_W = 9;
    localparam int ADC_W_DEF = 12;

    // Debounce time
    localparam int CLK_HZ = 100_000_000;
    localparam int DEBOUNCE_MS = 100;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);

endpackage

// [inc/otc_det_if.sv]
// Signals between the register top, the comparator and the debouncer.
// Assumes all three sit on the same system clock.
`timescale 1ns/100ps
interface otc_det_if;
    logic [7:0] limit;
    logic [8:0] reading9;
    logic overRaw;
    logic flag;
    logic rise;
    logic fall;
    logic [23:0] cnt;

    modport top (
        output limit,
        output reading9,
        input overRaw,
        input flag,
        input rise,
        input fall
    );
    modport cmp (
        input limit,
        input reading9,
        output overRaw
    );
    modport deb (
        input overRaw,
        output flag,
        output rise,
        output fall,
        output cnt
    );
endinterface

// [src/otc_compare.sv]
// Threshold widening and magnitude compare, purely combinational.
// Assumes limit and reading come from flops on the system clock.
`timescale 1ns/100ps
module otc_compare (
    // Clock and reset, for the checks only
    input wire logic clk,
    input wire logic rstn,
    // Detector signals
    otc_det_if.cmp det
);

    logic [8:0] thr9;

    always_comb begin
        thr9 = {1'b0, det.limit}; // R1
        det.overRaw = thr9 > det.reading9; // R2 R3
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_topBitBlocks;
        @(posedge clk) disable iff (!rstn)
        det.reading9[8] |-> !det.overRaw;
    endproperty
    a_topBitBlocks: assert property (p_topBitBlocks) // R1
        else $error("Raw condition set with reading above 255 codes");

    property p_overWhenBelow;
        @(posedge clk) disable iff (!rstn)
        (!det.reading9[8] && det.limit > det.reading9[7:0])
            |-> det.overRaw;
    endproperty
    a_overWhenBelow: assert property (p_overWhenBelow) // R3
        else $error("Raw condition missing with reading below limit");

endmodule

// [src/otc_debounce.sv]
// Debouncer: flag follows the raw condition only after it has
// disagreed with the flag for a full run of cycles.
// Assumes an asynchronous active-low reset and a clock enable.
`timescale 1ns/100ps
module otc_debounce #(
    parameter int COUNT = otc_pkg::DEBOUNCE_CYCLES
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic clkEn,
    // Detector signals
    otc_det_if.deb det
);

    if (COUNT < 1 || COUNT > 24'hFFFFFF) begin : g_chk
        $error("Debounce count out of range");
    end

    localparam logic [23:0] LAST = 24'(COUNT - 1);

    logic flag_reg, flag_next;
    logic [23:0] cnt_reg, cnt_next;

    // A single agreeing cycle restarts the run, so a noisy reading
    // near the threshold never toggles the flag.
    always_comb begin
        flag_next = flag_reg;
        cnt_next = cnt_reg;
        if (clkEn) begin
            if (det.overRaw == flag_reg) begin
                cnt_next = 24'h000000;
            end else if (cnt_reg == LAST) begin
                flag_next = det.overRaw; // R4 R7
                cnt_next = 24'h000000;
            end else begin
                cnt_next = cnt_reg + 24'h000001; // R4
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag_reg <= 1'b0; // R7
            cnt_reg <= 24'h000000;
        end else begin
            flag_reg <= flag_next;
            cnt_reg <= cnt_next;
        end
    end

    assign det.flag = flag_reg;
    assign det.cnt = cnt_reg;
    assign det.rise = flag_next && !flag_reg;
    assign det.fall = !flag_next && flag_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_changeOnlyAfterRun;
        @(posedge clk) disable iff (!rstn)
        $changed(flag_reg) |-> $past(cnt_reg) == LAST
            && $past(det.overRaw) != $past(flag_reg) && $past(clkEn);
    endproperty
    a_changeOnlyAfterRun: assert property (p_changeOnlyAfterRun) // R4
        else $error("Flag changed before the debounce run completed");

    property p_clearAfterRun;
        @(posedge clk) disable iff (!rstn)
        (flag_reg && !det.overRaw && clkEn && cnt_reg == LAST)
            |=> !flag_reg ##1 !flag_reg || det.overRaw;
    endproperty
    a_clearAfterRun: assert property (p_clearAfterRun) // R7
        else $error("Flag not cleared after a full clear run");

    property p_clearAtReset;
        @(posedge clk) disable iff (!rstn)
        $rose(rstn) |-> !flag_reg;
    endproperty
    a_clearAtReset: assert property (p_clearAtReset) // R7
        else $error("Flag not clear after reset");

    c_rise: cover property (@(posedge clk) disable iff (!rstn)
        $rose(flag_reg));
    c_fall: cover property (@(posedge clk) disable iff (!rstn)
        $fell(flag_reg));

endmodule

// [src/overtemp_threshold_compare.sv]
// Top of the second-channel over-temperature comparator: register
// port, interrupt logic, reset synchroniser, comparator and debouncer.
// Assumes the ADC result and the register master share sys_clk.
//
// How it works
// R1: Threshold is zero above eight programmed bits.
// R2: Compare against upper nine ADC result bits.
// R3: Flag sets when threshold exceeds the reading.
// R4: Flag changes only after 100 ms steady.
// R5: Each code is 3.125 mV, 256 codes.
// R6: Software keeps threshold codes within 2 to 244.
// R7: Flag clears after debounced recovery; reset clears it.
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
module overtemp_threshold_compare #(
    parameter int ADC_W = otc_pkg::ADC_W_DEF,
    parameter int DEBOUNCE_CYCLES = otc_pkg::DEBOUNCE_CYCLES
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clkEn,
    // Temperature sense result
    input wire logic [ADC_W-1:0] tempSenseTwo,
    // Register port
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    // Fault and interrupt outputs
    output logic overtempProtectTwo,
    output logic irq
);

    if (ADC_W < otc_pkg::CMP_W) begin : g_chk
        $error("ADC result narrower than the compare width");
    end

    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] off);
        hit = (a == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reset synchroniser; runs regardless of clkEn so a held-off
    // enable can never hold the design in reset.

    logic rstMeta_reg, rstn;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta_reg <= 1'b0;
            rstn <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstn <= rstMeta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Detector

    otc_det_if det ();

    logic [7:0] limit_reg, limit_next;

    assign det.limit = limit_reg;
    assign det.reading9 = tempSenseTwo[ADC_W-1 -: otc_pkg::CMP_W]; // R2

    otc_compare u_cmp (
        .clk(sys_clk),
        .rstn(rstn),
        .det(det)
    );

    otc_debounce #(
        .COUNT(DEBOUNCE_CYCLES)
    ) u_deb (
        .clk(sys_clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .det(det)
    );

    assign overtempProtectTwo = det.flag;

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [2:0] status_reg, status_next;
    logic [2:0] mask_reg, mask_next;
    logic [7:0] rdData_reg, rdData_next;
    logic wrEn, rdEn, badLimit;
    logic [2:0] events, rdClear;

    always_comb begin
        wrEn = regWrStb && clkEn;
        rdEn = regRdStb && clkEn;
        // The device cannot stop a bad code; it only reports it
        badLimit = wrEn && hit(regAddr, otc_pkg::ADDR_LIMIT)
            && (regWrData < otc_pkg::LIMIT_MIN
                || regWrData > otc_pkg::LIMIT_MAX); // R6
        events = 3'h0;
        events[otc_pkg::ST_RISE] = det.rise && clkEn;
        events[otc_pkg::ST_FALL] = det.fall && clkEn;
        events[otc_pkg::ST_BADLIM] = badLimit;
        rdClear = (rdEn && hit(regAddr, otc_pkg::ADDR_STATUS))
            ? status_reg : 3'h0;

        limit_next = limit_reg;
        mask_next = mask_reg;
        if (wrEn && hit(regAddr, otc_pkg::ADDR_LIMIT)) begin
            limit_next = regWrData; // R5
        end
        if (wrEn && hit(regAddr, otc_pkg::ADDR_MASK)) begin
            mask_next = regWrData[otc_pkg::ST_W-1:0];
        end

        // Set wins over the read clear in the same cycle
        status_next = (status_reg & ~rdClear) | events;

        rdData_next = 8'h00;
        if (rdEn) begin
            case (regAddr)
                otc_pkg::ADDR_LIMIT: rdData_next = limit_reg;
                otc_pkg::ADDR_STATUS: rdData_next = {5'h00, status_reg};
                otc_pkg::ADDR_MASK: rdData_next = {5'h00, mask_reg};
                otc_pkg::ADDR_STATE: begin
                    rdData_next[otc_pkg::SR_FLAG] = det.flag;
                    rdData_next[otc_pkg::SR_RAW] = det.overRaw;
                end
                default: rdData_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            limit_reg <= otc_pkg::LIMIT_RESET;
            mask_reg <= otc_pkg::MASK_RESET;
            status_reg <= otc_pkg::STATUS_RESET;
            rdData_reg <= 8'h00;
        end else if (clkEn) begin
            limit_reg <= limit_next;
            mask_reg <= mask_next;
            status_reg <= status_next;
            rdData_reg <= rdData_next;
        end
    end

    assign regRdData = rdData_reg;
    assign irq = |(status_reg & mask_reg);

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_limitStore;
        @(posedge sys_clk) disable iff (!rstn)
        (wrEn && regAddr == otc_pkg::ADDR_LIMIT)
            |=> limit_reg == $past(regWrData);
    endproperty
    a_limitStore: assert property (p_limitStore) // R5
        else $error("Threshold code not stored as written");

    property p_readLimit;
        @(posedge sys_clk) disable iff (!rstn)
        (rdEn && regAddr == otc_pkg::ADDR_LIMIT)
            |=> regRdData == $past(limit_reg) ##1 regRdData == 8'h00
                || $past(rdEn);
    endproperty
    a_readLimit: assert property (p_readLimit) // R5
        else $error("Threshold read data wrong or held too long");

    property p_compareSource;
        @(posedge sys_clk) disable iff (!rstn)
        (tempSenseTwo[ADC_W-1] == 1'b0
            && {1'b0, limit_reg} > tempSenseTwo[ADC_W-1 -: 9])
            |-> det.overRaw;
    endproperty
    a_compareSource: assert property (p_compareSource) // R2
        else $error("Compare not taken from the upper nine bits");

    property p_riseSticky;
        @(posedge sys_clk) disable iff (!rstn)
        (det.rise && clkEn) |=> status_reg[otc_pkg::ST_RISE]
            && overtempProtectTwo;
    endproperty
    a_riseSticky: assert property (p_riseSticky) // R3
        else $error("Rise of the flag not recorded in status");

    property p_fallSticky;
        @(posedge sys_clk) disable iff (!rstn)
        (det.fall && clkEn) |=> status_reg[otc_pkg::ST_FALL]
            && !overtempProtectTwo;
    endproperty
    a_fallSticky: assert property (p_fallSticky) // R7
        else $error("Fall of the flag not recorded in status");

    property p_badLimitSticky;
        @(posedge sys_clk) disable iff (!rstn)
        badLimit |=> status_reg[otc_pkg::ST_BADLIM];
    endproperty
    a_badLimitSticky: assert property (p_badLimitSticky) // R6
        else $error("Out-of-range threshold write not recorded");

    property p_goodLimitQuiet;
        @(posedge sys_clk) disable iff (!rstn)
        (wrEn && regAddr == otc_pkg::ADDR_LIMIT
            && regWrData >= otc_pkg::LIMIT_MIN
            && regWrData <= otc_pkg::LIMIT_MAX) |-> !badLimit;
    endproperty
    a_goodLimitQuiet: assert property (p_goodLimitQuiet) // R6
        else $error("Legal threshold code reported as out of range");

    property p_statusRead;
        @(posedge sys_clk) disable iff (!rstn)
        (rdEn && regAddr == otc_pkg::ADDR_STATUS)
            |=> regRdData == {5'h00, $past(status_reg)};
    endproperty
    a_statusRead: assert property (p_statusRead) // R3
        else $error("Status read data wrong");

    property p_statusClear;
        @(posedge sys_clk) disable iff (!rstn)
        (rdEn && regAddr == otc_pkg::ADDR_STATUS && events == 3'h0)
            |=> status_reg == 3'h0;
    endproperty
    a_statusClear: assert property (p_statusClear) // R3
        else $error("Status bits not cleared by their read");

    property p_maskStore;
        @(posedge sys_clk) disable iff (!rstn)
        (wrEn && regAddr == otc_pkg::ADDR_MASK)
            |=> mask_reg == $past(regWrData[otc_pkg::ST_W-1:0]);
    endproperty
    a_maskStore: assert property (p_maskStore) // R3
        else $error("Mask not stored as written");

    property p_maskRead;
        @(posedge sys_clk) disable iff (!rstn)
        (rdEn && regAddr == otc_pkg::ADDR_MASK)
            |=> regRdData == {5'h00, $past(mask_reg)};
    endproperty
    a_maskRead: assert property (p_maskRead) // R3
        else $error("Mask read data wrong");

    property p_stateRead;
        @(posedge sys_clk) disable iff (!rstn)
        (rdEn && regAddr == otc_pkg::ADDR_STATE)
            |=> regRdData == {6'h00, $past(det.overRaw),
                $past(overtempProtectTwo)};
    endproperty
    a_stateRead: assert property (p_stateRead) // R3
        else $error("State read data wrong");

    property p_unmappedRead;
        @(posedge sys_clk) disable iff (!rstn)
        (rdEn && regAddr != otc_pkg::ADDR_LIMIT
            && regAddr != otc_pkg::ADDR_STATUS
            && regAddr != otc_pkg::ADDR_MASK
            && regAddr != otc_pkg::ADDR_STATE) |=> regRdData == 8'h00;
    endproperty
    a_unmappedRead: assert property (p_unmappedRead) // R5
        else $error("Unmapped address read not zero");

    property p_rdDataIdle;
        @(posedge sys_clk) disable iff (!rstn)
        (!regRdStb && clkEn) |=> regRdData == 8'h00;
    endproperty
    a_rdDataIdle: assert property (p_rdDataIdle) // R5
        else $error("Read data held past its cycle");

    // Nothing but the reset synchroniser and the raw compare moves while the enable is low, the debounce run included
    property p_frozenWhenOff;
        @(posedge sys_clk) disable iff (!rstn)
        !clkEn |=> $stable(limit_reg) && $stable(mask_reg)
            && $stable(status_reg) && $stable(det.cnt)
            && $stable(overtempProtectTwo);
    endproperty
    a_frozenWhenOff: assert property (p_frozenWhenOff) // R4
        else $error("State changed while the clock enable was low");

    property p_cntBelowRun;
        @(posedge sys_clk) disable iff (!rstn)
        int'(det.cnt) < DEBOUNCE_CYCLES;
    endproperty
    a_cntBelowRun: assert property (p_cntBelowRun) // R4
        else $error("Debounce count ran past its end");

    property p_riseNeedsRaw;
        @(posedge sys_clk) disable iff (!rstn)
        det.rise |-> det.overRaw;
    endproperty
    a_riseNeedsRaw: assert property (p_riseNeedsRaw) // R3
        else $error("Flag rising with no raw condition");

    c_badLimit: cover property (@(posedge sys_clk) disable iff (!rstn)
        badLimit);
    c_irq: cover property (@(posedge sys_clk) disable iff (!rstn)
        $rose(irq));
    c_frozen: cover property (@(posedge sys_clk) disable iff (!rstn)
        !clkEn && det.overRaw && !det.flag);

endmodule

// [bench/overtemp_threshold_compare_tb.sv]
// Self-checking bench for the over-temperature threshold comparator.
// Assumes the design files and the package are compiled before it.
`timescale 1ns/100ps
module overtemp_threshold_compare_tb;
    // Short debounce so the run stays brief
    localparam int DEB = 8;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic clkEn = 1'b1;
    logic [11:0] tempSenseTwo = 12'h000;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0] regWrData = 8'h00;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic [7:0] regRdData;
    logic overtempProtectTwo;
    logic irq;
    int badCount = 0;
    int numChecks = 0;
    logic [31:0] seed = 32'h0000001D;
    logic [7:0] d;
    logic [7:0] lim;
    logic [8:0] r9;
    int n;
    logic [7:0] badLims [6] = '{8'h00, 8'h01, 8'h02, 8'hF4, 8'hF5, 8'hFF};

    overtemp_threshold_compare #(
        .ADC_W(12),
        .DEBOUNCE_CYCLES(DEB)
    ) u_dut (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clkEn(clkEn),
        .tempSenseTwo(tempSenseTwo),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWrStb(regWrStb),
        .regRdStb(regRdStb),
        .regRdData(regRdData),
        .overtempProtectTwo(overtempProtectTwo),
        .irq(irq)
    );

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // Zero above the eight limit bits, so readings from 256 up never trip
    function automatic logic expRaw(input logic [7:0] l, input logic [8:0] r);
        return {1'b0, l} > r;
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp,
                       input string msg);
        numChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= v;
        regWrStb <= 1'b1;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        #1 v = regRdData;
    endtask

    task automatic rdChk(input logic [15:0] a, input logic [7:0] e,
                         input string msg);
        logic [7:0] v;
        rd(a, v);
        chk({1'b0, v}, {1'b0, e}, msg);
    endtask

    // Low three bits are noise the compare must ignore
    task automatic setTemp(input logic [8:0] r);
        @(posedge sys_clk);
        seed = xs(seed);
        tempSenseTwo <= {r, seed[2:0]};
    endtask

    task automatic waitFlag(input logic lvl, output int cnt);
        cnt = 0;
        for (int i = 0; i < 50; i++) begin
            @(posedge sys_clk);
            #1 cnt++;
            if (overtempProtectTwo === lvl)
                return;
        end
        chk(9'h000, 9'h001, "flag wait timed out");
        conclude();
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk);
        chk(9'h000, 9'h001, "global timeout");
        conclude();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({8'h00, overtempProtectTwo}, 9'h000, "flag after reset");
        chk({8'h00, irq}, 9'h000, "irq after reset");
        rdChk(otc_pkg::ADDR_LIMIT, otc_pkg::LIMIT_RESET, "limit reset");
        rdChk(otc_pkg::ADDR_STATUS, 8'h00, "status reset");
        rdChk(otc_pkg::ADDR_MASK, 8'h00, "mask reset");
        rdChk(otc_pkg::ADDR_STATE, 8'h00, "state reset");
        rdChk(16'h1234, 8'h00, "unmapped read");
        // Random and edge compares; software stays in 2..244 here
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            lim = 8'h02 + 8'(seed[15:8] % 243);
            seed = xs(seed);
            r9 = {seed[8] & seed[9], seed[7:0]};
            if (i == 0) r9 = {1'b0, lim - 8'h01};
            if (i == 1) r9 = {1'b0, lim};
            if (i == 2) r9 = {1'b1, lim - 8'h01};
            wr(otc_pkg::ADDR_LIMIT, lim);
            rdChk(otc_pkg::ADDR_LIMIT, lim, "limit readback");
            setTemp(r9);
            rd(otc_pkg::ADDR_STATE, d);
            chk({8'h00, d[otc_pkg::SR_RAW]}, {8'h00, expRaw(lim, r9)},
                "raw compare");
        end
        setTemp(9'h1FF);
        repeat (DEB + 4) @(posedge sys_clk);
        rd(otc_pkg::ADDR_STATUS, d);
        chk({8'h00, overtempProtectTwo}, 9'h000, "flag settled low");
        // Debounce: a short excursion must not move the flag
        wr(otc_pkg::ADDR_LIMIT, 8'h64);
        wr(otc_pkg::ADDR_MASK, 8'h07);
        setTemp(9'h032);
        repeat (DEB - 2) @(posedge sys_clk);
        setTemp(9'h1FF);
        repeat (DEB) @(posedge sys_clk);
        #1 chk({8'h00, overtempProtectTwo}, 9'h000, "glitch passed");
        setTemp(9'h032);
        waitFlag(1'b1, n);
        chk(9'(n), 9'(DEB), "rise delay");
        chk({8'h00, irq}, 9'h001, "irq on rise");
        rdChk(otc_pkg::ADDR_STATUS, 8'h01, "status rise");
        @(posedge sys_clk);
        #1 chk({8'h00, irq}, 9'h000, "irq after clear");
        // Falling edge with its status bit masked out
        wr(otc_pkg::ADDR_MASK, 8'h01);
        setTemp(9'h1FF);
        waitFlag(1'b0, n);
        chk(9'(n), 9'(DEB), "fall delay");
        chk({8'h00, irq}, 9'h000, "masked irq");
        wr(otc_pkg::ADDR_MASK, 8'h02);
        @(posedge sys_clk);
        #1 chk({8'h00, irq}, 9'h001, "unmasked irq");
        rdChk(otc_pkg::ADDR_STATUS, 8'h02, "status fall");
        // Out-of-range codes are kept but flagged
        wr(otc_pkg::ADDR_MASK, 8'h04);
        foreach (badLims[k]) begin
            wr(otc_pkg::ADDR_LIMIT, badLims[k]);
            @(posedge sys_clk);
            #1 chk({8'h00, irq}, {8'h00, badLims[k] < 8'h02 ||
                   badLims[k] > 8'hF4}, "bad limit irq");
            rdChk(otc_pkg::ADDR_LIMIT, badLims[k], "limit kept");
            rdChk(otc_pkg::ADDR_STATUS,
                  (badLims[k] < 8'h02 || badLims[k] > 8'hF4) ? 8'h04 : 8'h00,
                  "bad limit status");
        end
        // Disabled clock freezes counter and ignores strobes
        @(posedge sys_clk);
        clkEn <= 1'b0;
        setTemp(9'h000);
        repeat (20) @(posedge sys_clk);
        #1 chk({8'h00, overtempProtectTwo}, 9'h000, "frozen flag");
        wr(otc_pkg::ADDR_LIMIT, 8'h10);
        @(posedge sys_clk);
        clkEn <= 1'b1;
        rdChk(otc_pkg::ADDR_LIMIT, 8'hFF, "write while disabled");
        waitFlag(1'b1, n);
        // Reset in mid-run clears the flag and the limit
        @(posedge sys_clk);
        resetn <= 1'b0;
        @(posedge sys_clk);
        #1 chk({8'h00, overtempProtectTwo}, 9'h000, "flag in reset");
        chk({8'h00, irq}, 9'h000, "irq in reset");
        @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rdChk(otc_pkg::ADDR_LIMIT, otc_pkg::LIMIT_RESET, "limit re-reset");
        conclude();
    end
endmodule
